// ==== design/afc_pkg.sv ====
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - Bits 7:4 set backpressure duration; unused in full duplex.
// - Bit 3 jams multicast frames at threshold, half duplex only.
// - Bit 2 jams broadcast frames at threshold, half duplex only.
// - Bit 1 jams own-address frames at threshold, half duplex only.
// - Bit 0 acts on any frame; enables full duplex pause frames.
// - Any-frame half duplex: jam on valid preamble, no address decode.
// - Any-frame full duplex: pause frame on first valid preamble after threshold.
// - Any-frame bit overrides bits 3 through 1.
// - Duration codes map to 5..600 us; 10 Mb/s adds 2.2 us.
// - High threshold in 64-byte units; one pause per crossing.
// - After pause, zero-time pause when level falls below low threshold.
// - Half duplex: each matching frame jammed for selected duration.
// - No pause frames or backpressure while transmitter disabled.
package afc_pkg;
    localparam logic [7:0]  FLOW_CONTROL_CONFIG_ADDR   = 8'h00;
    localparam logic [31:0] FLOW_CONTROL_CONFIG_RESET  = 32'h0000_0000;
    localparam logic [31:0] FLOW_CONTROL_CONFIG_WMASK  = 32'h00FF_FFFF;
    localparam int          HI_LSB         = 16;
    localparam int          LO_LSB         = 8;
    localparam int          DUR_LSB        = 4;
    localparam int          BIT_MULT       = 3;
    localparam int          BIT_BRD        = 2;
    localparam int          BIT_ADD        = 1;
    localparam int          BIT_ANY        = 0;
    localparam int          UNIT_BYTES_LG2 = 6;
    localparam int          CLK_MHZ        = 10;
    // Duration times in tenths of a microsecond
    localparam int          EXTRA_10M_DUS  = 22;
    localparam int          CNT_W          = 16;

    typedef enum logic [1:0] {
        AFC_IDLE  = 2'b00,
        AFC_ARMED = 2'b01,
        AFC_SENT  = 2'b11
    } afc_fd_t;

    // Duration in 0.1 us at 100 Mb/s
    function automatic int afc_dur_dus(input logic [3:0] code);
        case (code)
            4'h0: afc_dur_dus = 50;
            4'h1: afc_dur_dus = 100;
            4'h2: afc_dur_dus = 150;
            4'h3: afc_dur_dus = 250;
            4'h4: afc_dur_dus = 500;
            default: afc_dur_dus = (int'(code) - 3) * 500;
        endcase
    endfunction

    // Cycle count for code and speed (10 MHz: 1 cycle per 0.1 us)
    function automatic logic [CNT_W-1:0] afc_dur_cyc(input logic [3:0] code,
                                                     input logic       speed_100);
        int dus;
        dus = afc_dur_dus(code) + (speed_100 ? 0 : EXTRA_10M_DUS);
        afc_dur_cyc = CNT_W'((dus * CLK_MHZ) / 10);
    endfunction
endpackage

// ==== design/afc_trigger.sv ====
`timescale 1ns/10ps
module afc_trigger
#(
    parameter int LEVEL_W = 14
)
(
    input  wire logic               clk,              // MAC clock
    input  wire logic               sys_rst,          // Async reset, high
    input  wire logic               psel,             // APB select
    input  wire logic               penable,          // APB enable
    input  wire logic               pwrite,           // APB write
    input  wire logic [7:0]         paddr,            // APB byte address
    input  wire logic [31:0]        pwdata,           // APB write data
    output logic      [31:0]        prdata,           // APB read data
    output logic                    pready,           // APB ready
    output logic                    pslverr,          // APB error
    input  wire logic [LEVEL_W-1:0] rx_fifo_level,    // RX data FIFO bytes
    input  wire logic               full_duplex,      // Duplex mode
    input  wire logic               speed_100,        // 100 Mb/s link
    input  wire logic               tx_enable,        // Transmitter enabled
    input  wire logic               rx_preamble,      // Valid preamble pulse
    input  wire logic               rx_da_valid,      // Address decoded pulse
    input  wire logic               rx_da_mcast,      // Multicast frame
    input  wire logic               rx_da_bcast,      // Broadcast frame
    input  wire logic               rx_da_match,      // Own address frame
    output logic                    backpressure,     // Jam request
    output logic                    pause_req,        // Pause frame pulse
    output logic                    pause_zero        // Zero-time pause pulse
);
    import afc_pkg::*;

    //------------------------------------------------------------
    // Register access
    //------------------------------------------------------------
    logic [31:0] cfg_r;
    wire         acc      = psel & penable;
    wire         hit      = (paddr == FLOW_CONTROL_CONFIG_ADDR);
    wire         wr_cfg   = acc & pwrite & hit & pready;
    wire         rd_any   = psel & ~penable & ~pwrite;
    wire  [31:0] rd_val   = hit ? cfg_r : 32'h0000_0000;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cfg_r <= FLOW_CONTROL_CONFIG_RESET;
        else if (wr_cfg)
            cfg_r <= pwdata & FLOW_CONTROL_CONFIG_WMASK;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= rd_any ? rd_val : 32'h0000_0000;
        end
    end

    //------------------------------------------------------------
    // Threshold compare
    //------------------------------------------------------------
    wire [7:0]  hi_thr  = cfg_r[HI_LSB+:8];
    wire [7:0]  lo_thr  = cfg_r[LO_LSB+:8];
    wire [3:0]  dur     = cfg_r[DUR_LSB+:4];
    wire        t_any   = cfg_r[BIT_ANY];
    wire [LEVEL_W+1:0] hi_bytes = (LEVEL_W+2)'({hi_thr, UNIT_BYTES_LG2'(0)});
    wire [LEVEL_W+1:0] lo_bytes = (LEVEL_W+2)'({lo_thr, UNIT_BYTES_LG2'(0)});
    wire [LEVEL_W+1:0] lvl      = (LEVEL_W+2)'(rx_fifo_level);
    wire        hi_reached = (lvl >= hi_bytes);
    wire        lo_below   = (lvl < lo_bytes);
    wire        afc_en     = |cfg_r[3:0];

    //------------------------------------------------------------
    // Half-duplex backpressure
    //------------------------------------------------------------
    wire hd_sel_hit = rx_da_valid & ((cfg_r[BIT_MULT] & rx_da_mcast)
                                   | (cfg_r[BIT_BRD] & rx_da_bcast)
                                   | (cfg_r[BIT_ADD] & rx_da_match));
    // Any-frame reacts to preamble and masks the others
    wire hd_event = t_any ? rx_preamble : hd_sel_hit;
    wire hd_fire  = ~full_duplex & tx_enable & hi_reached & hd_event;
    wire [CNT_W-1:0] dur_cyc = afc_dur_cyc(dur, speed_100);

    logic [CNT_W-1:0] bp_cnt_r;
    logic [CNT_W-1:0] bp_cnt_nxt;
    // Duration ignored in full duplex; jam dropped if tx off
    assign bp_cnt_nxt = (full_duplex | ~tx_enable) ? CNT_W'(0) :
                        hd_fire ? dur_cyc :
                        (bp_cnt_r != 0) ? bp_cnt_r - CNT_W'(1) : CNT_W'(0);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bp_cnt_r     <= '0;
            backpressure <= 1'b0;
        end
        else
        begin
            bp_cnt_r     <= bp_cnt_nxt;
            backpressure <= (bp_cnt_nxt != 0);
        end
    end

    //------------------------------------------------------------
    // Full-duplex pause frames
    //------------------------------------------------------------
    afc_fd_t fd_r;
    afc_fd_t fd_nxt;
    wire fd_ok     = full_duplex & t_any & tx_enable;
    wire fd_send   = (fd_r == AFC_ARMED) & fd_ok & rx_preamble;
    wire fd_resume = (fd_r == AFC_SENT) & tx_enable & lo_below;

    always_comb
    begin
        fd_nxt = fd_r;
        case (fd_r)
            AFC_IDLE:
            begin
                if (hi_reached & fd_ok) fd_nxt = AFC_ARMED;
            end
            AFC_ARMED:
            begin
                if (!fd_ok || !hi_reached) fd_nxt = AFC_IDLE;
                else if (rx_preamble)      fd_nxt = AFC_SENT;
            end
            AFC_SENT:
            begin
                if (fd_resume) fd_nxt = AFC_IDLE;
            end
            default:   fd_nxt = AFC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fd_r       <= AFC_IDLE;
            pause_req  <= 1'b0;
            pause_zero <= 1'b0;
        end
        else
        begin
            fd_r       <= fd_nxt;
            pause_req  <= fd_send;
            pause_zero <= fd_resume;
        end
    end

    //------------------------------------------------------------
    // Register checks
    //------------------------------------------------------------
    a_apb_ready: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable) |=> pready)
        else $error("apb ready late");

    a_apb_one_wait: assert property (@(posedge clk) disable iff (sys_rst)
        !(psel && !penable) |=> !pready)
        else $error("apb ready without setup");

    a_apb_err: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable && paddr != FLOW_CONTROL_CONFIG_ADDR) |=> pslverr)
        else $error("unmapped access not refused");

    a_wr_lands: assert property (@(posedge clk) disable iff (sys_rst)
        (acc && pready && pwrite && hit) |=> cfg_r == ($past(pwdata) & FLOW_CONTROL_CONFIG_WMASK))
        else $error("config write lost");

    a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_r[31:24] == 8'h00)
        else $error("reserved config bits set");

    a_rd_data: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable && !pwrite && hit) |=> prdata == $past(cfg_r))
        else $error("read data wrong");

    //------------------------------------------------------------
    // Backpressure checks
    //------------------------------------------------------------
    a_bp_start: assert property (@(posedge clk) disable iff (sys_rst)
        hd_fire |=> backpressure)
        else $error("backpressure not raised on trigger");

    a_bp_fdx_off: assert property (@(posedge clk) disable iff (sys_rst)
        full_duplex |=> !backpressure)
        else $error("backpressure in full duplex");

    a_bp_fdx_cnt: assert property (@(posedge clk) disable iff (sys_rst)
        full_duplex |=> bp_cnt_r == '0)
        else $error("duration counter runs in full duplex");

    a_tx_off_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !tx_enable |=> !backpressure && !pause_req && !pause_zero)
        else $error("flow control active with tx off");

    a_bp_len_min: assert property (@(posedge clk) disable iff (sys_rst)
        (hd_fire && dur == 4'h0 && speed_100) ##1 (!full_duplex && tx_enable)[*8]
        |-> backpressure)
        else $error("backpressure ended early");

    a_bp_reload: assert property (@(posedge clk) disable iff (sys_rst)
        hd_fire |=> bp_cnt_r == $past(dur_cyc))
        else $error("duration not loaded on trigger");

    a_bp_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (bp_cnt_r > CNT_W'(1) && !full_duplex && tx_enable) |=> backpressure)
        else $error("backpressure dropped inside duration");

    a_bp_end: assert property (@(posedge clk) disable iff (sys_rst)
        (bp_cnt_r == CNT_W'(1) && !hd_fire) |=> !backpressure)
        else $error("backpressure longer than duration");

    a_bp_no_thr: assert property (@(posedge clk) disable iff (sys_rst)
        (!hi_reached && bp_cnt_r == '0) |=> !backpressure)
        else $error("backpressure below threshold");

    a_any_masks: assert property (@(posedge clk) disable iff (sys_rst)
        (t_any && !rx_preamble && bp_cnt_r == 0 && !full_duplex && tx_enable)
        |=> !backpressure)
        else $error("selective bits acted under any-frame");

    a_any_preamble: assert property (@(posedge clk) disable iff (sys_rst)
        (t_any && rx_preamble && hi_reached && !full_duplex && tx_enable) |=> backpressure)
        else $error("any-frame preamble missed");

    a_sel_hd: assert property (@(posedge clk) disable iff (sys_rst)
        (!t_any && hd_sel_hit && hi_reached && !full_duplex && tx_enable) |=> backpressure)
        else $error("selective trigger missed");

    //------------------------------------------------------------
    // Pause checks
    //------------------------------------------------------------
    a_pause_once: assert property (@(posedge clk) disable iff (sys_rst)
        pause_req |-> fd_r == AFC_SENT && !$past(pause_req))
        else $error("second pause in one crossing");

    a_pause_cause: assert property (@(posedge clk) disable iff (sys_rst)
        pause_req |-> $past(rx_preamble) && $past(hi_reached) && $past(t_any))
        else $error("pause without preamble at threshold");

    a_pause_hd_off: assert property (@(posedge clk) disable iff (sys_rst)
        !full_duplex |=> !pause_req)
        else $error("pause frame in half duplex");

    a_pause_sel_off: assert property (@(posedge clk) disable iff (sys_rst)
        !t_any |=> !pause_req)
        else $error("pause without any-frame trigger");

    a_fd_arm: assert property (@(posedge clk) disable iff (sys_rst)
        (fd_r == AFC_IDLE && hi_reached && fd_ok) |=> fd_r == AFC_ARMED)
        else $error("pause logic not armed at threshold");

    a_fd_disarm: assert property (@(posedge clk) disable iff (sys_rst)
        (fd_r == AFC_ARMED && !fd_ok) |=> fd_r == AFC_IDLE)
        else $error("pause logic stays armed");

    a_zero_cause: assert property (@(posedge clk) disable iff (sys_rst)
        pause_zero |-> $past(fd_r) == AFC_SENT && $past(lo_below))
        else $error("zero pause without prior pause");

    a_zero_idle: assert property (@(posedge clk) disable iff (sys_rst)
        pause_zero |-> fd_r == AFC_IDLE)
        else $error("zero pause left state busy");

    a_zero_wait: assert property (@(posedge clk) disable iff (sys_rst)
        (fd_r == AFC_SENT && !lo_below) |=> !pause_zero)
        else $error("zero pause above low threshold");

    //------------------------------------------------------------
    // Cover points
    //------------------------------------------------------------
    c_hd_jam:   cover property (@(posedge clk) disable iff (sys_rst) hd_fire);
    c_pause:    cover property (@(posedge clk) disable iff (sys_rst) pause_req);
    c_zero:     cover property (@(posedge clk) disable iff (sys_rst) pause_zero);
    c_cfg_wr:   cover property (@(posedge clk) disable iff (sys_rst) wr_cfg && afc_en);
    c_bp_10m:   cover property (@(posedge clk) disable iff (sys_rst) hd_fire && !speed_100);
endmodule

// ==== testbench/afc_peer.sv ====
`timescale 1ns/10ps
module afc_peer
(
    input  wire logic       clk,          // MAC clock
    input  wire logic       go,           // Start one frame
    input  wire logic [1:0] kind,         // 0 own, 1 bcast, 2 mcast, 3 other
    output logic            rx_preamble,  // Preamble pulse
    output logic            rx_da_valid,  // Address decoded pulse
    output logic            rx_da_mcast,  // Multicast class
    output logic            rx_da_bcast,  // Broadcast class
    output logic            rx_da_match   // Own address class
);
    logic [2:0] step_r = 3'h0;
    logic [1:0] kind_r = 2'h0;
    logic       flip_r = 1'b0;
    // Class lines carry noise outside the address pulse
    assign rx_preamble = step_r == 3'h1;
    assign rx_da_valid = step_r == 3'h4;
    assign rx_da_mcast = rx_da_valid ? kind_r == 2'h2 : flip_r;
    assign rx_da_bcast = rx_da_valid ? kind_r == 2'h1 : ~flip_r;
    assign rx_da_match = rx_da_valid ? kind_r == 2'h0 : flip_r;
    always @(posedge clk)
    begin
        flip_r <= ~flip_r;
        kind_r <= go ? kind : kind_r;
        step_r <= go ? 3'h1 : (step_r == 3'h0 || step_r == 3'h5) ? 3'h0 : step_r + 3'h1;
    end
endmodule

// ==== testbench/tb_auto_flow_control_trigger.sv ====
`timescale 1ns/10ps
module tb_auto_flow_control_trigger;
    logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic        fdx = 0, spd = 1, txen = 1, er;
    logic [7:0]  paddr = 8'h00, hi = 8'h02;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [13:0] lvl = 14'h0000;
    logic [1:0]  kind = 2'h0;
    logic [3:0]  code = 4'h0;
    logic        pready, pslverr, pre, dav, mc, bc, mt, bp, pq, pz;
    int          failures = 0, total_checks = 0, n, np = 0, nz = 0, i;
    always #50 clk = ~clk;
    always @(negedge clk)
    begin
        np += (pq === 1'b1);
        nz += (pz === 1'b1);
    end
    afc_trigger u_dut
    (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_fifo_level(lvl), .full_duplex(fdx), .speed_100(spd), .tx_enable(txen),
        .rx_preamble(pre), .rx_da_valid(dav), .rx_da_mcast(mc), .rx_da_bcast(bc),
        .rx_da_match(mt), .backpressure(bp), .pause_req(pq), .pause_zero(pz)
    );
    afc_peer u_peer
    (
        .clk(clk), .go(go), .kind(kind), .rx_preamble(pre), .rx_da_valid(dav),
        .rx_da_mcast(mc), .rx_da_bcast(bc), .rx_da_match(mt)
    );
    //------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------
    task final_report;
        $display("failures=%0d total_checks=%0d", failures, total_checks);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    // Low threshold kept one below high
    task cfg(input logic [3:0] b);
        apb(1, 8'h00, {8'h00, hi, hi - 8'h01, code, b});
    endtask
    // Send a frame, then count backpressure cycles
    task frame(input logic [1:0] k);
        kind <= k;
        go <= 1;
        @(posedge clk);
        go <= 0;
        n = 0;
        for (i = 0; i < 7000; i++)
        begin
            @(negedge clk);
            if (bp === 1'b1)
                n++;
            else if (n > 0 || i > 20)
                break;
        end
        @(posedge clk);
    endtask
    function automatic int dur(input logic [3:0] c, input logic s);
        dur = (c > 4) ? (c - 3) * 500 : (c == 4) ? 500 : (c == 3) ? 250 : 50 * (c + 1);
        dur += s ? 0 : 22;
    endfunction
    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h97d0));
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        apb(0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1, 8'h00, 32'hFFFF_FFFF);
        apb(0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h00FF_FFFF);
        apb(1, 8'h04, 32'h0000_0000);
        chk(er, 1);
        for (int k = 0; k < 3; k++)
        begin
            hi = 8'($urandom_range(255, 2));
            code = 4'($urandom);
            spd <= 1'($urandom);
            lvl <= {hi, 6'h00};
            cfg(4'h2 << k);
            frame(2'(k));
            chk(n, dur(code, spd));
            frame(2'h3);
            chk(n, 0);
        end
        lvl <= {hi, 6'h00} - 14'h0001;
        frame(2'h2);
        chk(n, 0);
        lvl <= {hi, 6'h00};
        cfg(4'h9);
        frame(2'h2);
        chk(n, dur(code, spd));
        txen <= 0;
        frame(2'h3);
        chk(n, 0);
        txen <= 1;
        fdx <= 1;
        cfg(4'h8);
        frame(2'h2);
        chk(n, 0);
        chk(np, 0);
        cfg(4'h1);
        frame(2'h3);
        frame(2'h3);
        chk(n, 0);
        chk(np, 1);
        lvl <= {hi - 8'h01, 6'h00} - 14'h0001;
        repeat (5) @(posedge clk);
        chk(nz, 1);
        final_report();
    end
endmodule
